// ### design/ttc_pkg.sv
// Constants, types and register map of the thermal throttle controller
// How it works
// - Automatic throttle overrides software-forced throttle
// - Automatic activation only at maximum temperature
// - Trip threshold fixed, never software-visible
// - Keep snooping; latch interrupts, serve when clocked
// - Clock throttle gates core clocks at 50%
// - Modulation period shrinks as frequency rises
// - Duty cycle fixed, not software changeable
// - Cool again: stop modulation, circuit inactive
// - Hysteresis between activation and release
// - Frequency step requests lowest operating point
// - After cooling, return to last requested point
// - Mode enables set by configuration register writes
// - Both enabled: frequency step wins
// - Diode offset held in readable register
// - Forced clock throttle added if step fails
// - Hot indicator low while above trip
// - Higher-point requests deferred during step throttling
package ttc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned STEP_SETTLE_NS = 100000;
  localparam int unsigned STEP_SETTLE_CYC =
    (STEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MOD_BASE_NS    = 1000;
  localparam int unsigned MOD_BASE_CYC   =
    (MOD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES    = 3;

  // ==========================================================
  // Widths and operating points
  localparam int CNT_W    = 16;
  localparam int OP_W     = 3;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = 4;
  localparam int DIODE_W  = 8;
  localparam logic [OP_W-1:0] LOWEST_POINT = 3'h0;
  localparam logic [OP_W-1:0] TOP_POINT    = 3'h7;
  localparam logic [OP_W-1:0] OPREQ_RST    = 3'h0;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OPREQ  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_DIODE  = 4'hC;

  localparam int CTRL_W          = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam int CTRL_CTM_EN     = 0;
  localparam int CTRL_FSM_EN     = 1;
  localparam int CTRL_FORCE_CTM  = 2;
  localparam int CTRL_SW_THROT   = 3;

  localparam int ST_ACTIVE       = 0;
  localparam int ST_STEP         = 1;
  localparam int ST_MOD          = 2;
  localparam int ST_CLK_ON       = 3;
  localparam int ST_HOT          = 4;
  localparam int ST_IRQ_PEND     = 5;
  localparam int ST_POINT_LSB    = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // ==========================================================
  // Throttle states
  typedef enum logic [1:0] {
    TS_IDLE,
    TS_STEP,
    TS_STEP_MOD,
    TS_GATE
  } ttc_state_t;

endpackage

// ### design/ttc_mod_if.sv
// Link between throttle control and the clock modulator
`timescale 1ns/1ps
interface ttc_mod_if
  import ttc_pkg::*;
();
  logic             run;
  logic [CNT_W-1:0] half_len;
  logic             clk_on;

  modport ctl (output run, output half_len, input clk_on);
  modport gen (input run, input half_len, output clk_on);
endinterface

// ### design/ttc_clk_mod.sv
// Fixed 50 percent core clock modulator
`timescale 1ns/1ps
module ttc_clk_mod
  import ttc_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Control
  ttc_mod_if.gen    m
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             on_r;
  logic             on_nxt;
  logic             started_r;
  logic             started_nxt;

  assign m.clk_on = on_r;

  // ==========================================================
  // Phase counter
  // Same length for both halves, so no duty setting exists
  always_comb begin
    cnt_nxt     = cnt_r;
    on_nxt      = on_r;
    started_nxt = started_r;
    if (!m.run) begin
      cnt_nxt     = '0;
      on_nxt      = 1'b1;
      started_nxt = 1'b0;
    end else if (!started_r) begin
      // Stop first: cooling begins at once
      cnt_nxt     = '0;
      on_nxt      = 1'b0;
      started_nxt = 1'b1;
    end else if (cnt_r >= m.half_len - CNT_W'(1)) begin
      cnt_nxt = '0;
      on_nxt  = !on_r;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_r     <= '0;
      on_r      <= 1'b1;
      started_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      on_r      <= on_nxt;
      started_r <= started_nxt;
    end
  end

endmodule // ttc_clk_mod

// ### design/ttc_top.sv
// Thermal throttle controller with AXI4-Lite register slave
`timescale 1ns/1ps
module ttc_top
  import ttc_pkg::*;
#(
  // Arbitrary neutral factory offset value
  parameter logic [DIODE_W-1:0] DIODE_OFFSET = 8'h00
)(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [DATA_W-1:0] i_s_axi_wdata,
  input  wire logic [STRB_W-1:0] i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [DATA_W-1:0]      o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  // Temperature comparator flags, asynchronous
  input  wire logic              i_temp_trip,
  input  wire logic              i_temp_clear,
  // Interrupt requests, core clock domain
  input  wire logic              i_irq_req,
  // Core side
  output logic                   o_core_clk_en,
  output logic                   o_snoop_en,
  output logic                   o_irq_take,
  output logic                   o_irq_pending,
  output logic [OP_W-1:0]        o_op_point,
  output logic                   o_op_change,
  output logic                   o_thermal_control_circuit,
  output logic                   o_hot_indicator_n
);

  // ==========================================================
  // Declarations
  logic [SYNC_STAGES-1:0] trip_sync_r;
  logic [SYNC_STAGES-1:0] trip_sync_nxt;
  logic [SYNC_STAGES-1:0] clear_sync_r;
  logic [SYNC_STAGES-1:0] clear_sync_nxt;
  logic                   trip_s_r;
  logic                   trip_s_nxt;
  logic                   clear_s_r;
  logic                   clear_s_nxt;

  logic                   awready_r;
  logic                   awready_nxt;
  logic                   wready_r;
  logic                   wready_nxt;
  logic                   aw_held_r;
  logic                   aw_held_nxt;
  logic                   w_held_r;
  logic                   w_held_nxt;
  logic [ADDR_W-1:0]      waddr_r;
  logic [ADDR_W-1:0]      waddr_nxt;
  logic [DATA_W-1:0]      wdata_r;
  logic [DATA_W-1:0]      wdata_nxt;
  logic                   wlane_r;
  logic                   wlane_nxt;
  logic                   bvalid_r;
  logic                   bvalid_nxt;
  logic [1:0]             bresp_r;
  logic [1:0]             bresp_nxt;
  logic                   arready_r;
  logic                   arready_nxt;
  logic                   rvalid_r;
  logic                   rvalid_nxt;
  logic [DATA_W-1:0]      rdata_r;
  logic [DATA_W-1:0]      rdata_nxt;
  logic [1:0]             rresp_r;
  logic [1:0]             rresp_nxt;
  logic                   wr_ctrl;
  logic                   wr_opreq;
  logic [DATA_W-1:0]      wr_value;

  logic [CTRL_W-1:0]      ctrl_r;
  logic [CTRL_W-1:0]      ctrl_nxt;
  logic [OP_W-1:0]        req_r;
  logic [OP_W-1:0]        req_nxt;
  logic [OP_W-1:0]        point_r;
  logic [OP_W-1:0]        point_nxt;
  logic                   change_r;
  logic                   change_nxt;
  ttc_state_t             state_r;
  ttc_state_t             state_nxt;
  logic [CNT_W-1:0]       settle_r;
  logic [CNT_W-1:0]       settle_nxt;
  logic                   clk_en_r;
  logic                   clk_en_nxt;
  logic                   pend_r;
  logic                   pend_nxt;
  logic                   take_r;
  logic                   take_nxt;
  logic                   snoop_r;
  logic                   hot_n_r;
  logic                   hot_n_nxt;
  logic                   active_r;
  logic                   active_nxt;
  logic                   hot;
  logic                   cool;
  logic                   mod_run;
  logic [OP_W:0]          steps;

  ttc_mod_if mod_if ();

  ttc_clk_mod u_clk_mod (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .m        (mod_if.gen)
  );

  // ==========================================================
  // Trip and clear flag synchronisers
  // Stage 0 feeds only stage 1; stages 1 and 2 must agree
  always_comb begin
    trip_sync_nxt  = {trip_sync_r[SYNC_STAGES-2:0], i_temp_trip};
    clear_sync_nxt = {clear_sync_r[SYNC_STAGES-2:0], i_temp_clear};
    trip_s_nxt     = trip_s_r;
    clear_s_nxt    = clear_s_r;
    if (trip_sync_r[SYNC_STAGES-1] == trip_sync_r[SYNC_STAGES-2]) begin
      trip_s_nxt = trip_sync_r[SYNC_STAGES-2];
    end
    if (clear_sync_r[SYNC_STAGES-1] == clear_sync_r[SYNC_STAGES-2]) begin
      clear_s_nxt = clear_sync_r[SYNC_STAGES-2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      trip_sync_r  <= '0;
      clear_sync_r <= '0;
      trip_s_r     <= 1'b0;
      clear_s_r    <= 1'b0;
    end else begin
      trip_sync_r  <= trip_sync_nxt;
      clear_sync_r <= clear_sync_nxt;
      trip_s_r     <= trip_s_nxt;
      clear_s_r    <= clear_s_nxt;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  always_comb begin
    logic have_aw;
    logic have_w;
    logic do_wr;
    logic ar_hs;
    logic [ADDR_W-1:0] a;
    logic lane;
    have_aw   = aw_held_r | (i_s_axi_awvalid & awready_r);
    have_w    = w_held_r | (i_s_axi_wvalid & wready_r);
    do_wr     = have_aw & have_w & !bvalid_r;
    ar_hs     = i_s_axi_arvalid & arready_r;
    a         = aw_held_r ? waddr_r : i_s_axi_awaddr;
    lane      = w_held_r ? wlane_r : i_s_axi_wstrb[0];
    wr_value  = w_held_r ? wdata_r : i_s_axi_wdata;
    waddr_nxt = (i_s_axi_awvalid & awready_r) ? i_s_axi_awaddr : waddr_r;
    wdata_nxt = (i_s_axi_wvalid & wready_r) ? i_s_axi_wdata : wdata_r;
    wlane_nxt = (i_s_axi_wvalid & wready_r) ? i_s_axi_wstrb[0] : wlane_r;
    wr_ctrl   = do_wr & lane & (a == ADDR_CTRL);
    wr_opreq  = do_wr & lane & (a == ADDR_OPREQ);
    aw_held_nxt = have_aw & !do_wr;
    w_held_nxt  = have_w & !do_wr;
    bvalid_nxt  = do_wr | (bvalid_r & !i_s_axi_bready);
    bresp_nxt   = bresp_r;
    if (do_wr) begin
      // Status and offset are read-only: write answered SLVERR
      bresp_nxt = ((a == ADDR_CTRL) || (a == ADDR_OPREQ)) ?
                  RESP_OKAY : RESP_SLVERR;
    end
    awready_nxt = !aw_held_nxt & !bvalid_nxt;
    wready_nxt  = !w_held_nxt & !bvalid_nxt;
    rvalid_nxt  = ar_hs | (rvalid_r & !i_s_axi_rready);
    arready_nxt = !rvalid_nxt;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (ar_hs) begin
      rdata_nxt = DATA_ZERO;
      rresp_nxt = RESP_OKAY;
      case (i_s_axi_araddr)
        ADDR_CTRL: begin
          rdata_nxt[CTRL_W-1:0] = ctrl_r;
        end
        ADDR_OPREQ: begin
          rdata_nxt[OP_W-1:0] = req_r;
        end
        ADDR_STATUS: begin
          rdata_nxt[ST_ACTIVE]   = active_r;
          rdata_nxt[ST_STEP]     = (state_r == TS_STEP) |
                                   (state_r == TS_STEP_MOD);
          rdata_nxt[ST_MOD]      = mod_run;
          rdata_nxt[ST_CLK_ON]   = clk_en_r;
          rdata_nxt[ST_HOT]      = trip_s_r;
          rdata_nxt[ST_IRQ_PEND] = pend_r;
          rdata_nxt[ST_POINT_LSB +: OP_W] = point_r;
        end
        ADDR_DIODE: begin
          rdata_nxt[DIODE_W-1:0] = DIODE_OFFSET;
        end
        default: begin
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= DATA_ZERO;
      wlane_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= DATA_ZERO;
      rresp_r   <= RESP_OKAY;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wlane_r   <= wlane_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ==========================================================
  // Throttle control
  // Trip level lives in the sensor; no register can move it
  assign hot  = trip_s_r;
  // Release needs the lower clear level: no chatter near trip
  assign cool = clear_s_r & !trip_s_r;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    req_nxt    = req_r;
    state_nxt  = state_r;
    settle_nxt = settle_r;
    if (wr_ctrl) begin
      ctrl_nxt = wr_value[CTRL_W-1:0];
    end
    if (wr_opreq) begin
      // Recorded when strobe bit 0 is set; held back only in the step states
      req_nxt = wr_value[OP_W-1:0];
    end
    case (state_r)
      TS_IDLE: begin
        settle_nxt = '0;
        if (hot && ctrl_r[CTRL_FSM_EN]) begin
          state_nxt = TS_STEP;
        end else if (hot && ctrl_r[CTRL_CTM_EN]) begin
          state_nxt = TS_GATE;
        end
      end
      TS_STEP: begin
        if (cool || !ctrl_r[CTRL_FSM_EN]) begin
          state_nxt = TS_IDLE;
        end else if (settle_r >= CNT_W'(STEP_SETTLE_CYC)) begin
          if (ctrl_r[CTRL_FORCE_CTM]) begin
            state_nxt = TS_STEP_MOD;
          end
        end else begin
          settle_nxt = settle_r + CNT_W'(1);
        end
      end
      TS_STEP_MOD: begin
        if (cool || !ctrl_r[CTRL_FSM_EN]) begin
          state_nxt = TS_IDLE;
        end
      end
      TS_GATE: begin
        if (cool || !ctrl_r[CTRL_CTM_EN]) begin
          state_nxt = TS_IDLE;
        end
      end
      default: begin
        state_nxt = TS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_r   <= CTRL_RST;
      req_r    <= OPREQ_RST;
      state_r  <= TS_IDLE;
      settle_r <= '0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      req_r    <= req_nxt;
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // ==========================================================
  // Modulation, operating point and core-side outputs
  // Software force only acts while automatic control is idle
  assign mod_run = (state_r == TS_GATE) || (state_r == TS_STEP_MOD) ||
                   ((state_r == TS_IDLE) && ctrl_r[CTRL_SW_THROT]);
  // Fewer core cycles per half at higher points
  assign steps = (OP_W+1)'(TOP_POINT) - (OP_W+1)'(point_r) +
                 (OP_W+1)'(1);
  assign mod_if.run      = mod_run;
  assign mod_if.half_len = CNT_W'(CNT_W'(MOD_BASE_CYC) * CNT_W'(steps));

  always_comb begin
    point_nxt = req_r;
    if ((state_r == TS_STEP) || (state_r == TS_STEP_MOD)) begin
      point_nxt = LOWEST_POINT;
    end
    change_nxt = (point_nxt != point_r);
    clk_en_nxt = mod_if.clk_on;
    take_nxt   = pend_r & clk_en_r;
    // A new request beats the delivery that clears the flag
    pend_nxt   = (pend_r & !take_nxt) | i_irq_req;
    hot_n_nxt  = !trip_s_r;
    active_nxt = (state_nxt != TS_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      point_r  <= OPREQ_RST;
      change_r <= 1'b0;
      clk_en_r <= 1'b1;
      take_r   <= 1'b0;
      pend_r   <= 1'b0;
      snoop_r  <= 1'b0;
      hot_n_r  <= 1'b1;
      active_r <= 1'b0;
    end else begin
      point_r  <= point_nxt;
      change_r <= change_nxt;
      clk_en_r <= clk_en_nxt;
      take_r   <= take_nxt;
      pend_r   <= pend_nxt;
      snoop_r  <= 1'b1;
      hot_n_r  <= hot_n_nxt;
      active_r <= active_nxt;
    end
  end

  assign o_s_axi_awready   = awready_r;
  assign o_s_axi_wready    = wready_r;
  assign o_s_axi_bresp     = bresp_r;
  assign o_s_axi_bvalid    = bvalid_r;
  assign o_s_axi_arready   = arready_r;
  assign o_s_axi_rdata     = rdata_r;
  assign o_s_axi_rresp     = rresp_r;
  assign o_s_axi_rvalid    = rvalid_r;
  assign o_core_clk_en     = clk_en_r;
  assign o_snoop_en        = snoop_r;
  assign o_irq_take        = take_r;
  assign o_irq_pending     = pend_r;
  assign o_op_point        = point_r;
  assign o_op_change       = change_r;
  assign o_thermal_control_circuit = active_r;
  assign o_hot_indicator_n = hot_n_r;

endmodule // ttc_top

// ### tb/ttc_properties.sv
// Port-level assertions for the thermal throttle controller
`timescale 1ns/1ps
module ttc_properties
  import ttc_pkg::*;
(
  // Clock and reset
  input wire logic            i_clk,
  input wire logic            i_resetn,
  // Bus handshakes
  input wire logic            i_s_axi_bready,
  input wire logic            i_s_axi_arvalid,
  input wire logic            o_s_axi_arready,
  input wire logic            o_s_axi_bvalid,
  input wire logic [1:0]      o_s_axi_bresp,
  input wire logic            o_s_axi_rvalid,
  // Core side
  input wire logic            i_irq_req,
  input wire logic            o_core_clk_en,
  input wire logic            o_snoop_en,
  input wire logic            o_irq_take,
  input wire logic            o_irq_pending,
  input wire logic [OP_W-1:0] o_op_point,
  input wire logic            o_op_change,
  input wire logic            o_thermal_control_circuit,
  input wire logic            o_hot_indicator_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // ==========================================================
  // Gated run length; the longest legal half is 160 cycles
  logic [15:0] off_r;
  logic [15:0] off_nxt;
  always_comb off_nxt = o_core_clk_en ? 16'h0000 : off_r + 16'h0001;
  always_ff @(posedge i_clk) off_r <= i_resetn ? off_nxt : 16'h0000;

  // ==========================================================
  // Properties
  AST_SNOOP_ON: assert property ($past(i_resetn) |-> o_snoop_en)
    else $error("snoop disabled");
  AST_IRQ_LATCH: assert property (i_irq_req |=> o_irq_pending)
    else $error("irq not latched");
  AST_IRQ_CLK: assert property (o_irq_take |->
    $past(o_irq_pending) && $past(o_core_clk_en))
    else $error("irq taken with clocks off");
  AST_OP_CHG: assert property ($changed(o_op_point) |-> o_op_change)
    else $error("point change not strobed");
  AST_OP_CAUSE: assert property (o_op_change |->
    $changed(o_op_point))
    else $error("strobe without point change");
  AST_ACTIVE_HOT: assert property ($rose(o_thermal_control_circuit)
    |-> !o_hot_indicator_n) else $error("throttle while not hot");
  AST_COOL_CLK: assert property ($fell(o_thermal_control_circuit)
    |-> ##[0:4] o_core_clk_en) else $error("clocks stay off");
  AST_OFF_MAX: assert property (off_r <= 16'h00A0)
    else $error("clock off half too long");
  AST_R_LAT: assert property (i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid) else $error("read answer late");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
endmodule // ttc_properties

bind ttc_top ttc_properties ttc_properties_inst (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_bresp(o_s_axi_bresp),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_irq_req(i_irq_req),
  .o_core_clk_en(o_core_clk_en), .o_snoop_en(o_snoop_en),
  .o_irq_take(o_irq_take), .o_irq_pending(o_irq_pending),
  .o_op_point(o_op_point), .o_op_change(o_op_change),
  .o_thermal_control_circuit(o_thermal_control_circuit),
  .o_hot_indicator_n(o_hot_indicator_n));

// ### tb/ttc_seq_model.sv
// Behavioural core clock gate and operating-point sequencer
`timescale 1ns/1ps
module ttc_seq_model
  import ttc_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  // Requests from the controller
  input  wire logic            i_core_clk_en,
  input  wire logic [OP_W-1:0] i_op_point,
  input  wire logic            i_op_change,
  // Observed behaviour
  output logic [OP_W-1:0]      o_applied,
  output logic [15:0]          o_last_on,
  output logic [15:0]          o_last_off
);
  logic        prev;
  logic [15:0] cnt;
  // Point applied only on the strobe, as a real sequencer would
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_applied  <= LOWEST_POINT;
      o_last_on  <= 16'h0000;
      o_last_off <= 16'h0000;
      prev       <= 1'b1;
      cnt        <= 16'h0000;
    end else begin
      if (i_op_change) o_applied <= i_op_point;
      prev <= i_core_clk_en;
      if (i_core_clk_en != prev) begin
        if (prev) o_last_on <= cnt;
        else o_last_off <= cnt;
        cnt <= 16'h0001;
      end else cnt <= cnt + 16'h0001;
    end
  end
endmodule // ttc_seq_model

// ### tb/thermal_throttle_control_tb.sv
// Self-checking bench for the thermal throttle controller
`timescale 1ns/1ps
module thermal_throttle_control_tb
  import ttc_pkg::*;
;
  // Arbitrary offset, nonzero so the readback means something
  localparam logic [DIODE_W-1:0] OFS = 8'h5A;
  logic              clk = 0, rstn = 0, trip = 0, clr = 1, irq = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              clk_en, snoop, take, pend, chg, act, hot_n;
  logic [1:0]        bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [OP_W-1:0]   opp, applied;
  logic [15:0]       last_on, last_off;
  int                n_fail = 0, n_checks = 0, waited;
  always #25 clk = ~clk;

  ttc_top #(.DIODE_OFFSET(OFS)) ttc_top_inst (
    .i_clk(clk), .i_resetn(rstn), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_temp_trip(trip), .i_temp_clear(clr),
    .i_irq_req(irq), .o_core_clk_en(clk_en), .o_snoop_en(snoop),
    .o_irq_take(take), .o_irq_pending(pend), .o_op_point(opp),
    .o_op_change(chg), .o_thermal_control_circuit(act),
    .o_hot_indicator_n(hot_n));
  ttc_seq_model ttc_seq_model_inst (
    .i_clk(clk), .i_resetn(rstn), .i_core_clk_en(clk_en),
    .i_op_point(opp), .i_op_change(chg), .o_applied(applied),
    .o_last_on(last_on), .o_last_off(last_off));

  // ==========================================================
  // Reporting
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic hang(input string nm);
    n_fail++;
    $display("[ERR] %s expected done seen timeout", nm);
    print_verdict();
  endtask

  // ==========================================================
  // Bus and wait helpers
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int k;
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awready) awv <= 0;
      if (wready) wv <= 0;
      if (bvalid) break;
    end
    if (k == 40) hang("write");
    bready <= 0;
    chk("bresp", bresp, er);
    @(posedge clk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    int k;
    araddr <= a; arv <= 1; rready <= 1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arready) arv <= 0;
      if (rvalid) break;
    end
    if (k == 40) hang("read");
    rready <= 0;
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
    @(posedge clk);
  endtask
  // Sel 0 throttle active, 1 core clock enable
  task automatic wt(input int s, input logic v, input int lim);
    logic x;
    for (waited = 0; waited < lim; waited++) begin
      @(posedge clk);
      x = s == 0 ? act : clk_en;
      if (x === v) return;
    end
    hang(s == 0 ? "throttle active" : "core clock");
  endtask
  task automatic heat(); trip <= 1; clr <= 0; endtask
  task automatic cool(); trip <= 0; clr <= 1; endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    axr(ADDR_CTRL, DATA_ZERO, RESP_OKAY);
    axr(ADDR_STATUS, 32'h0000_0008, RESP_OKAY);
    axw(ADDR_DIODE, 32'h0000_00FF, RESP_SLVERR);
    axr(ADDR_DIODE, {24'h00_0000, OFS}, RESP_OKAY);
    axw(ADDR_STATUS, 32'h0000_0001, RESP_SLVERR);
    axr(4'h2, DATA_ZERO, RESP_SLVERR);
    axw(ADDR_OPREQ, 32'h0000_0005, RESP_OKAY);
    axr(ADDR_OPREQ, 32'h0000_0005, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("op_point", opp, 3'h5);
  endtask
  task automatic t_gate(input logic [2:0] pt);
    int h;
    h = 20 * (8 - pt);
    axw(ADDR_OPREQ, {29'h0, pt}, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    heat();
    wt(0, 1, 10);
    chk("hot_n", hot_n, 1'b0);
    wt(1, 0, 300);
    irq <= 1;
    @(posedge clk);
    irq <= 0;
    repeat (2) @(posedge clk);
    chk("pend", pend, 1'b1);
    chk("take", take, 1'b0);
    chk("snoop", snoop, 1'b1);
    wt(1, 1, 200);
    wt(1, 0, 200);
    @(posedge clk);
    chk("off len", last_off, h);
    chk("on len", last_on, h);
    chk("pend", pend, 1'b0);
    trip <= 0;
    repeat (20) @(posedge clk);
    chk("hold", act, 1'b1);
    clr <= 1;
    wt(0, 0, 10);
    repeat (3) @(posedge clk);
    chk("clk_en", clk_en, 1'b1);
  endtask
  task automatic t_step();
    int k, lows;
    axw(ADDR_OPREQ, 32'h0000_0005, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0000_000B, RESP_OKAY);
    heat();
    wt(0, 1, 10);
    repeat (3) @(posedge clk);
    chk("op_point", opp, LOWEST_POINT);
    lows = 0;
    for (k = 0; k < 400; k++) begin
      @(posedge clk);
      if (clk_en !== 1'b1) lows++;
    end
    chk("gated", lows, 0);
    axw(ADDR_OPREQ, 32'h0000_0006, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("op_point", opp, LOWEST_POINT);
    axw(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    cool();
    wt(0, 0, 10);
    repeat (3) @(posedge clk);
    chk("op_point", opp, 3'h6);
    chk("applied", applied, 3'h6);
  endtask
  task automatic t_force();
    axw(ADDR_CTRL, 32'h0000_0007, RESP_OKAY);
    heat();
    wt(0, 1, 10);
    wt(1, 0, 2300);
    chk("settle", waited >= STEP_SETTLE_CYC, 1'b1);
    chk("op_point", opp, LOWEST_POINT);
    wt(1, 1, 200);
    cool();
    wt(0, 0, 10);
  endtask
  task automatic t_off();
    axw(ADDR_CTRL, DATA_ZERO, RESP_OKAY);
    heat();
    repeat (20) @(posedge clk);
    chk("active", act, 1'b0);
    chk("hot_n", hot_n, 1'b0);
    cool();
    repeat (10) @(posedge clk);
    chk("hot_n", hot_n, 1'b1);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    t_regs();
    t_gate(3'h0);
    t_gate(3'h4);
    t_step();
    t_force();
    t_off();
    print_verdict();
  end
endmodule // thermal_throttle_control_tb
